// *** rtl/imvu_top.sv ***
/*
 * imvu_top: interrupt mask and vector unit with Wishbone classic slave.
 * Assumes one clock, sources give one-cycle event pulses synchronous to
 * REF_CLK, and the core pulses IACK_STB during interrupt acknowledge.
 */
module imvu_top (
    input wire logic REF_CLK, // system clock, 40 MHz
    input wire logic RST_B, // async reset, active low
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_WE_I, // write enable
    input wire logic [imvu_pkg::ADDR_W-1:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [imvu_pkg::DATA_W-1:0] WB_DAT_I, // write data
    output logic [imvu_pkg::DATA_W-1:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // acknowledge
    output logic WB_ERR_O, // unmapped address
    input wire logic [imvu_pkg::NUM_SRC-1:0] SRC_EVENT, // hardware event pulses
    input wire logic IACK_STB, // core acknowledges
    output logic [15:0] IACK_PC, // vector as program counter
    output logic IRQ_REQ, // a pending interrupt exists
    output logic IRQ_O // unit status interrupt
);
    localparam int N = imvu_pkg::NUM_SRC;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [N-1:0] posted_r, posted_nxt;
    logic [N-1:0] enable_r, enable_nxt;
    logic soft_post_enable_r, soft_post_enable_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] smask_r, smask_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    logic [imvu_pkg::DATA_W-1:0] rdat_r, rdat_nxt;

    logic req, wr, rd, hit;
    logic [7:0] idx, wbyte, rbyte, vec;
    logic [N-1:0] pend;
    logic pend_any;

    assign req = WB_CYC_I && WB_STB_I && !ack_r && !err_r;
    assign idx = WB_ADR_I[9:2];
    assign wr = req && WB_WE_I && WB_SEL_I[0];
    assign rd = req && !WB_WE_I;
    assign wbyte = WB_DAT_I[7:0];

    // masked sources still post; the enable only gates pending
    // posted gated by enable
    assign pend = posted_r & enable_r;

    imvu_prio_enc #(
        .N(N)
    ) u_prio (
        .pend(pend),
        .any(pend_any),
        .vec(vec)
    );

    // ------------------------------------------------------------
    // address decode and read mux
    // ------------------------------------------------------------
    always_comb begin
        hit = 1'b1;
        rbyte = imvu_pkg::RESET_BYTE;
        unique case (idx)
            imvu_pkg::IDX_POSTED_ZERO: rbyte = posted_r[7:0];
            imvu_pkg::IDX_POSTED_ONE: rbyte = posted_r[15:8];
            imvu_pkg::IDX_POSTED_TWO: rbyte = posted_r[23:16];
            imvu_pkg::IDX_SOFT_CTRL: rbyte[imvu_pkg::SOFT_POST_BIT] = soft_post_enable_r;
            imvu_pkg::IDX_ENABLE_TWO: rbyte = enable_r[23:16] & imvu_pkg::ENABLE_TWO_VALID;
            imvu_pkg::IDX_ENABLE_ZERO: rbyte = enable_r[7:0];
            imvu_pkg::IDX_ENABLE_ONE: rbyte = enable_r[15:8];
            imvu_pkg::IDX_VECTOR: rbyte = vec;
            imvu_pkg::IDX_IRQ_STATUS: rbyte = {6'h00, stat_r};
            imvu_pkg::IDX_IRQ_MASK: rbyte = {6'h00, smask_r};
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------
    always_comb begin
        posted_nxt = posted_r;
        enable_nxt = enable_r;
        soft_post_enable_nxt = soft_post_enable_r;
        smask_nxt = smask_r;
        stat_nxt = stat_r;
        pc_nxt = pc_r;
        ack_nxt = req && hit;
        err_nxt = req && !hit;
        rdat_nxt = rdat_r;
        if (rd && hit) begin
            rdat_nxt = {24'h000000, rbyte};
        end
        if (wr) begin
            unique case (idx)
                imvu_pkg::IDX_POSTED_ZERO, imvu_pkg::IDX_POSTED_ONE, imvu_pkg::IDX_POSTED_TWO: begin
                    for (int b = 0; b < 8; b++) begin
                        if (soft_post_enable_r) begin
                            if (wbyte[b]) posted_nxt[8 * (idx - imvu_pkg::IDX_POSTED_ZERO) + b] = 1'b1;
                        end else begin
                            if (!wbyte[b]) posted_nxt[8 * (idx - imvu_pkg::IDX_POSTED_ZERO) + b] = 1'b0;
                        end
                    end
                end
                // soft post enable in bit 7
                imvu_pkg::IDX_SOFT_CTRL: soft_post_enable_nxt = wbyte[imvu_pkg::SOFT_POST_BIT];
                imvu_pkg::IDX_ENABLE_TWO: enable_nxt[23:16] = wbyte & imvu_pkg::ENABLE_TWO_VALID;
                imvu_pkg::IDX_ENABLE_ZERO: enable_nxt[7:0] = wbyte;
                imvu_pkg::IDX_ENABLE_ONE: enable_nxt[15:8] = wbyte;
                imvu_pkg::IDX_VECTOR: begin
                    posted_nxt = posted_r & ~enable_r;
                    stat_nxt[imvu_pkg::STAT_VCLR_BIT] = 1'b1;
                end
                imvu_pkg::IDX_IRQ_STATUS: stat_nxt = stat_r & ~wbyte[1:0];
                imvu_pkg::IDX_IRQ_MASK: smask_nxt = wbyte[1:0];
                default: ;
            endcase
        end
        // acknowledge loads vector, clears its source
        if (IACK_STB) begin
            pc_nxt = {8'h00, vec};
            for (int s = N - 1; s >= 0; s--) begin
                if (pend[s] && 8'(imvu_pkg::VEC_BASE + 8'(s) * imvu_pkg::VEC_STEP) == vec) begin
                    posted_nxt[s] = 1'b0;
                end
            end
        end
        // hardware events win over any clear in the same cycle
        posted_nxt = posted_nxt | SRC_EVENT;
        // status events set last so they beat a write-one clear
        if (pend_any) stat_nxt[imvu_pkg::STAT_PEND_BIT] = 1'b1;
        if (wr && idx == imvu_pkg::IDX_VECTOR) stat_nxt[imvu_pkg::STAT_VCLR_BIT] = 1'b1;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            posted_r <= '0;
            enable_r <= '0;
            soft_post_enable_r <= 1'b0;
            stat_r <= 2'h0;
            smask_r <= 2'h0;
            pc_r <= 16'h0000;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdat_r <= '0;
        end else begin
            posted_r <= posted_nxt;
            enable_r <= enable_nxt;
            soft_post_enable_r <= soft_post_enable_nxt;
            stat_r <= stat_nxt;
            smask_r <= smask_nxt;
            pc_r <= pc_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign WB_DAT_O = rdat_r;
    assign WB_ACK_O = ack_r;
    assign WB_ERR_O = err_r;
    assign IACK_PC = pc_r;
    assign IRQ_REQ = pend_any;
    assign IRQ_O = |(stat_r & smask_r);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    a_clear_on_zero: assert property (
        wr && idx == imvu_pkg::IDX_POSTED_ZERO && !soft_post_enable_r && !wbyte[4] && !SRC_EVENT[4]
        |=> !posted_r[4]) else $error("posted flag not cleared by zero");
    a_soft_post: assert property (
        wr && idx == imvu_pkg::IDX_POSTED_TWO && soft_post_enable_r && wbyte[2] |=> posted_r[18])
        else $error("software post missed");
    // posted but fully masked sources must give neither request nor vector
    a_masked_idle: assert property (
        posted_r != '0 && enable_r == '0 |-> !IRQ_REQ && vec == imvu_pkg::VEC_NONE)
        else $error("masked source became pending");
    a_group_zero_bit: assert property (
        wr && idx == imvu_pkg::IDX_ENABLE_ZERO |=> enable_r[7:0] == $past(wbyte))
        else $error("group zero enable mismatch");
    a_group_one_bit: assert property (
        wr && idx == imvu_pkg::IDX_ENABLE_ONE |=> enable_r[15:8] == $past(wbyte))
        else $error("group one enable mismatch");
    a_reserved_zero: assert property (
        !enable_r[23]) else $error("reserved enable bit set");
    a_vector_read: assert property (
        rd && idx == imvu_pkg::IDX_VECTOR |=> WB_ACK_O && WB_DAT_O[7:0] == $past(vec))
        else $error("vector read wrong");
    a_vector_clear: assert property (
        wr && idx == imvu_pkg::IDX_VECTOR && SRC_EVENT == '0 && !IACK_STB |=> (posted_r & enable_r) == '0)
        else $error("pending not cleared");
    a_masked_posts: assert property (
        SRC_EVENT[4] && !enable_r[4] |=> posted_r[4]) else $error("masked event not posted");
    a_ack_vector: assert property (
        IACK_STB |=> IACK_PC == {8'h00, $past(vec)}) else $error("acknowledge vector wrong");
    a_ack_drops: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");

    c_soft_post: cover property (wr && idx == imvu_pkg::IDX_POSTED_TWO && soft_post_enable_r);
    c_vector_clear: cover property (wr && idx == imvu_pkg::IDX_VECTOR && pend_any);
    c_iack: cover property (IACK_STB && pend_any);
    c_irq: cover property (IRQ_O);
endmodule : imvu_top

// *** inc/imvu_pkg.sv ***
/*
 * imvu_pkg: register offsets, field layout, reset values and vector
 * constants of the interrupt mask and vector unit.
 * Assumes a Wishbone classic slave with 8-bit register index addressing
 * (byte address = 4 * index) and 32-bit data.
 */
package imvu_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC = 24;
    localparam int REG_W = 8;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_POSTED_ZERO = 8'hDA;
    localparam logic [7:0] IDX_POSTED_ONE = 8'hDB;
    localparam logic [7:0] IDX_POSTED_TWO = 8'hDC;
    localparam logic [7:0] IDX_SOFT_CTRL = 8'hDE;
    localparam logic [7:0] IDX_ENABLE_TWO = 8'hDF;
    localparam logic [7:0] IDX_ENABLE_ZERO = 8'hE0;
    localparam logic [7:0] IDX_ENABLE_ONE = 8'hE1;
    localparam logic [7:0] IDX_VECTOR = 8'hE2;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hE4;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hE5;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int SOFT_POST_BIT = 7;
    localparam logic [7:0] ENABLE_TWO_VALID = 8'h7F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] STAT_VALID = 8'h03;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_VCLR_BIT = 1;

    // ------------------------------------------------------------
    // vectors: table base, step per source, value when idle
    // ------------------------------------------------------------
    localparam logic [7:0] VEC_BASE = 8'h04;
    localparam logic [7:0] VEC_STEP = 8'h04;
    localparam logic [7:0] VEC_NONE = 8'h00;
endpackage : imvu_pkg

// *** rtl/imvu_prio_enc.sv ***
/*
 * imvu_prio_enc: picks the lowest-numbered pending source and turns it
 * into its table vector. Purely combinational.
 * Assumes source 0 has the highest priority.
 */
module imvu_prio_enc #(
    parameter int N = imvu_pkg::NUM_SRC
) (
    input wire logic [N-1:0] pend, // pending sources
    output logic any, // something is pending
    output logic [7:0] vec // vector of the winner
);
    // ------------------------------------------------------------
    // scan from the top so the lowest index wins last
    // ------------------------------------------------------------
    always_comb begin
        any = 1'b0;
        vec = imvu_pkg::VEC_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                any = 1'b1;
                vec = 8'(imvu_pkg::VEC_BASE + 8'(i) * imvu_pkg::VEC_STEP);
            end
        end
    end
endmodule : imvu_prio_enc

// *** testbench/imvu_core_model.sv ***
/* imvu_core_model: processor core that dispatches interrupts.
   Assumes the unit's IRQ_REQ level and an arm input from the bench. */
module imvu_core_model (
    input wire logic clk, // system clock
    input wire logic rst_b, // reset, active low
    input wire logic arm, // global enable set by firmware
    input wire logic irq_req, // pending request level
    output logic iack_stb // acknowledge pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic taken_r; // stands in for a cleared global enable

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            iack_stb <= 1'b0;
            taken_r <= 1'b0;
        end else begin
            iack_stb <= arm && irq_req && !taken_r && !iack_stb;
            taken_r <= arm && (taken_r || iack_stb);
        end
    end
endmodule : imvu_core_model

// *** testbench/tb_top.sv ***
/* tb_top: self-checking bench of the interrupt mask and vector unit.
   Assumes a Wishbone classic master here and the core model beside. */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, cyc, stb, we, iack, arm, irq_req, irq_o, ack, err;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [23:0] ev;
    logic [15:0] pc;
    logic [7:0] regs [5] = '{8'hDE, 8'hDF, 8'hE0, 8'hE1, 8'hE2};
    int num_errors = 0;
    int num_checks = 0;

    imvu_top dut (.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .WB_ERR_O(err), .SRC_EVENT(ev), .IACK_STB(iack), .IACK_PC(pc), .IRQ_REQ(irq_req), .IRQ_O(irq_o));
    imvu_core_model core (.clk(clk), .rst_b(rst_b), .arm(arm), .irq_req(irq_req), .iack_stb(iack));

    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one classic cycle; request held until the edge that samples the answer
    task automatic bus(input logic w, input logic [3:0] s, input logic [7:0] idx, d, output logic [7:0] q,
        output logic e);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 16);
        q = rdat[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 16) chk("bus answer", 1'b0, 1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] idx, d);
        logic [7:0] q;
        logic e;
        bus(1'b1, 4'hF, idx, d, q, e);
    endtask : wr

    // read compare also demands no error answer
    task automatic rd(input string nm, input logic [7:0] idx, exp);
        logic [7:0] q;
        logic e;
        bus(1'b0, 4'hF, idx, 8'h00, q, e);
        chk(nm, {23'h000000, e, q}, {24'h000000, exp});
    endtask : rd

    task automatic pulse(input int src);
        @(posedge clk);
        ev <= 24'h000001 << src;
        @(posedge clk);
        ev <= 24'h000000;
    endtask : pulse

    function automatic logic [7:0] vec(input int i);
        return imvu_pkg::VEC_BASE + imvu_pkg::VEC_STEP * 8'(i);
    endfunction : vec

    task automatic t_reset;
        logic [7:0] q;
        logic e;
        foreach (regs[i]) rd("reset value", regs[i], 8'h00);
        bus(1'b0, 4'hF, 8'h10, 8'h00, q, e);
        chk("unmapped err", e, 1'b1);
        // a write without lane zero is acknowledged but changes nothing
        bus(1'b1, 4'hE, 8'hE0, 8'hFF, q, e);
        rd("lane zero off", 8'hE0, 8'h00);
    endtask : t_reset

    task automatic t_masked;
        pulse(4);
        rd("posted zero", 8'hDA, 8'h10);
        rd("idle vector", 8'hE2, imvu_pkg::VEC_NONE);
        chk("req masked", irq_req, 1'b0);
        wr(8'hE0, 8'h10);
        rd("vector gpio0", 8'hE2, vec(4));
        chk("req unmasked", irq_req, 1'b1);
        wr(8'hE1, 8'h01);
        pulse(8);
        rd("posted one", 8'hDB, 8'h01);
        rd("priority", 8'hE2, vec(4));
    endtask : t_masked

    // ones are ignored and the zero clears while soft posting is off
    task automatic t_clear;
        wr(8'hDA, 8'hEF);
        rd("cleared", 8'hDA, 8'h00);
        rd("vector ep0", 8'hE2, vec(8));
        // a masked post must survive the vector clear
        pulse(0);
        wr(8'hE2, 8'h5A);
        rd("after vclr", 8'hE2, imvu_pkg::VEC_NONE);
        chk("req after vclr", irq_req, 1'b0);
        rd("masked kept", 8'hDA, 8'h01);
    endtask : t_clear

    task automatic t_soft;
        wr(8'hDE, 8'hFF);
        rd("soft ctrl", 8'hDE, 8'h80);
        wr(8'hDC, 8'h04);
        rd("soft post", 8'hDC, 8'h04);
        wr(8'hDF, 8'h84);
        rd("reserved bit", 8'hDF, 8'h04);
        rd("vector ext2", 8'hE2, vec(18));
    endtask : t_soft

    task automatic t_ack;
        int n;
        arm <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (iack !== 1'b1 && n < 16);
        @(posedge clk);
        chk("ack pc", pc, {16'h0000, 8'h00, vec(18)});
        arm <= 1'b0;
        rd("posted after ack", 8'hDC, 8'h00);
        wr(8'hDE, 8'h00);
    endtask : t_ack

    // sticky status, mask and write-one clear of the unit interrupt
    task automatic t_irq;
        rd("status", 8'hE4, 8'h03);
        chk("irq masked", irq_o, 1'b0);
        wr(8'hE5, 8'h01);
        chk("irq raised", irq_o, 1'b1);
        wr(8'hE4, 8'h03);
        rd("status clear", 8'hE4, 8'h00);
        chk("irq cleared", irq_o, 1'b0);
    endtask : t_irq

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #(5000 * 25);
        num_errors++;
        results();
    end

    initial begin
        rst_b = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h000;
        wdat = 32'h00000000;
        sel = 4'h0;
        ev = 24'h000000;
        arm = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_masked();
        t_clear();
        t_soft();
        t_ack();
        t_irq();
        results();
    end
endmodule : tb_top
